// ===== logic/fcpwm_pkg.sv
// Register map, field layout and types of the four channel PWM controller
package fcpwm_pkg;
  // ****************************************
  // Global register byte offsets
  // ****************************************
  localparam int         ADDR_W   = 12;
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_ENA  = 12'h004;
  localparam logic [11:0] OFF_DIS  = 12'h008;
  localparam logic [11:0] OFF_SR   = 12'h00c;
  localparam logic [11:0] OFF_IER  = 12'h010;
  localparam logic [11:0] OFF_IDR  = 12'h014;
  localparam logic [11:0] OFF_IMR  = 12'h018;
  localparam logic [11:0] OFF_ISR  = 12'h01c;
  localparam logic [11:0] OFF_ICLR = 12'h020;
  // ****************************************
  // Channel pages: page 0x2, 0x20 bytes per channel
  // ****************************************
  localparam logic [3:0] CH_PAGE = 4'h2;
  localparam logic [4:0] CH_CMR  = 5'h00;
  localparam logic [4:0] CH_DUTY_VALUE = 5'h04;
  localparam logic [4:0] CH_PERIOD_VALUE = 5'h08;
  localparam logic [4:0] CH_CCNT = 5'h0c;
  localparam logic [4:0] CH_CUPD = 5'h10;
  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int DIVA_LSB = 0;
  localparam int PREA_LSB = 8;
  localparam int DIVB_LSB = 16;
  localparam int PREB_LSB = 24;
  localparam int MODE_W   = 11;
  localparam int PRE_W    = 10;
  localparam logic [3:0]  PRE_MAX  = 4'ha;
  localparam logic [3:0]  SEL_DIVIDED_CLOCK_A = 4'hb;
  localparam logic [3:0]  SEL_DIVIDED_CLOCK_B = 4'hc;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_MASK = 11'h70f;
  // Channel mode word, low bits of the mode register
  typedef struct packed {
    logic       upd_period;
    logic       pol_high;
    logic       centre;
    logic [3:0] spare;
    logic [3:0] clk_sel;
  } fcpwm_mode_t;
  typedef enum logic {
    CNT_UP   = 1'b0,
    CNT_DOWN = 1'b1
  } fcpwm_dir_t;
endpackage

// ===== logic/fcpwm_top.sv
// Four channel PWM controller with APB register slave and period interrupt
//
// Contract
// - Writing one to a disable bit stops that channel output; zeros do nothing.
// - Channel status bit reads one while the channel is enabled.
// - Writing one to an interrupt enable bit sets that mask bit.
// - Writing one to an interrupt disable bit clears that mask bit.
// - Mask register reads one for each enabled period interrupt.
// - Status flag sets once a channel period completed since last read.
// - Reading interrupt status clears the flags it returned.
// - Clock select: master clock over 2^n for 0..10, divided A, B.
// - Alignment bit zero gives left aligned, one gives centre aligned.
// - Polarity bit sets the level each period begins at.
// - With update target one, update value replaces period at period start.
// - With update target zero, update value replaces duty at period start.
// - Duty register keeps and uses only its low 16 bits.
// - Writing one to an enable bit starts that channel output.
// - Unmasked period end raises interrupt until status is read.
// - Update value is held until the current period ends.
// - Counter clears on enable and, when left aligned, after it reaches one below the period value.
`timescale 1ns/1ps
module fcpwm_top
  import fcpwm_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int CNT_W  = 16
) (
  input  wire logic              core_clk, // 10 MHz master clock
  input  wire logic              rst,      // Asynchronous reset, high
  input  wire logic              psel,     // APB select
  input  wire logic              penable,  // APB access phase
  input  wire logic              pwrite,   // APB write
  input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
  input  wire logic [31:0]       pwdata,   // APB write data
  output logic      [31:0]       prdata,   // APB read data
  output logic                   pready,   // APB ready
  output logic                   pslverr,  // Unmapped address
  output logic      [NUM_CH-1:0] pwm_out,  // Channel waveforms
  output logic                   irq       // Period interrupt, level
);
  // Channel page decode uses three index bits
  if (NUM_CH < 1 || NUM_CH > 8 || CNT_W < 2 || CNT_W > 32) begin : g_chk
    $error("fcpwm_top: NUM_CH or CNT_W out of range");
  end

  // ****************************************
  // Bus decode
  // ****************************************
  logic              setup_ph, acc_ph, wr_acc, rd_acc;
  logic              glob_pg, ch_pg, ch_reg_ok, ch_ok, glob_ok, mapped;
  logic [2:0]        ch_idx;
  logic [4:0]        ch_off;
  logic [NUM_CH-1:0] wbits;
  logic              wr_mode, wr_ena, wr_dis, wr_ier, wr_idr, wr_iclr;
  logic              rd_isr_done;

  // Zero wait state slave; errors only for holes in the map
  assign setup_ph    = psel & ~penable;
  assign acc_ph      = psel & penable;
  assign wr_acc      = acc_ph & pwrite;
  assign rd_acc      = acc_ph & ~pwrite;
  assign glob_pg     = paddr[11:8] == 4'h0;
  assign ch_pg       = paddr[11:8] == CH_PAGE;
  assign ch_idx      = paddr[7:5];
  assign ch_off      = paddr[4:0];
  assign ch_reg_ok   = ch_off == CH_CMR || ch_off == CH_DUTY_VALUE || ch_off == CH_PERIOD_VALUE
                    || ch_off == CH_CCNT || ch_off == CH_CUPD;
  assign ch_ok       = ch_pg && ({29'h0, ch_idx} < NUM_CH) && ch_reg_ok;
  assign glob_ok     = glob_pg && paddr[1:0] == 2'h0 && paddr[7:0] <= OFF_ICLR[7:0];
  assign mapped      = ch_ok || glob_ok;
  assign pready      = 1'b1;
  assign pslverr     = acc_ph & ~mapped;
  assign wbits       = pwdata[NUM_CH-1:0];
  assign wr_mode     = wr_acc && paddr == OFF_MODE;
  assign wr_ena      = wr_acc && paddr == OFF_ENA;
  assign wr_dis      = wr_acc && paddr == OFF_DIS;
  assign wr_ier      = wr_acc && paddr == OFF_IER;
  assign wr_idr      = wr_acc && paddr == OFF_IDR;
  assign wr_iclr     = wr_acc && paddr == OFF_ICLR;
  assign rd_isr_done = rd_acc && paddr == OFF_ISR;

  // ****************************************
  // Global state
  // ****************************************
  logic [31:0]       gmode_reg;
  logic [NUM_CH-1:0] chen_reg, imr_reg, isr_reg, isr_taken_reg;
  logic [NUM_CH-1:0] chen_next, imr_next, isr_next, pend;
  logic [31:0]       prdata_reg, rd_mux;
  logic [PRE_W-1:0]  pre_cnt_reg;

  // Enable wins over nothing: enable and disable are separate writes
  assign chen_next = (chen_reg | (wr_ena ? wbits : '0))
                   & ~(wr_dis ? wbits : '0);
  assign imr_next  = (imr_reg | (wr_ier ? wbits : '0))
                   & ~(wr_idr ? wbits : '0);
  // Clear only what the read returned; a new period end always sets
  assign isr_next  = (isr_reg & ~(rd_isr_done ? isr_taken_reg : '0)
                   & ~(wr_iclr ? wbits : '0)) | pend;
  assign irq       = |(isr_reg & imr_reg);

  // Global registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gmode_reg     <= RST_ZERO;
      chen_reg      <= '0;
      imr_reg       <= '0;
      isr_reg       <= '0;
      isr_taken_reg <= '0;
      prdata_reg    <= RST_ZERO;
      pre_cnt_reg   <= '0;
    end else begin
      if (wr_mode) gmode_reg <= pwdata;
      chen_reg    <= chen_next;
      imr_reg     <= imr_next;
      isr_reg     <= isr_next;
      pre_cnt_reg <= pre_cnt_reg + 1'b1;
      // Read data is sampled in setup and held through the access
      if (setup_ph) begin
        prdata_reg    <= rd_mux;
        isr_taken_reg <= isr_reg | pend;
      end
    end
  end
  assign prdata = prdata_reg;

  // ****************************************
  // Clock sources
  // ****************************************
  logic [12:0] src_tick;
  logic [1:0]  div_tick;
  logic [7:0]  div_cnt_reg [2];

  // Code n ticks once every 2^n master clocks
  assign src_tick[0] = 1'b1;
  for (genvar n = 1; n <= PRE_W; n++) begin : g_pre
    assign src_tick[n] = &pre_cnt_reg[n-1:0];
  end
  assign src_tick[11] = div_tick[0];
  assign src_tick[12] = div_tick[1];

  // Divided clocks A and B; a zero factor turns the clock off
  for (genvar k = 0; k < 2; k++) begin : g_div
    logic [7:0] dfac;
    logic [3:0] dpre;
    logic       dsrc;
    assign dfac        = gmode_reg[(k ? DIVB_LSB : DIVA_LSB) +: 8];
    assign dpre        = gmode_reg[(k ? PREB_LSB : PREA_LSB) +: 4];
    assign dsrc        = (dpre <= PRE_MAX) && src_tick[dpre];
    assign div_tick[k] = dsrc && dfac != 8'h00 && div_cnt_reg[k] >= dfac - 8'h01;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) div_cnt_reg[k] <= 8'h00;
      else if (div_tick[k] || dfac == 8'h00) div_cnt_reg[k] <= 8'h00;
      else if (dsrc) div_cnt_reg[k] <= div_cnt_reg[k] + 8'h01;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  fcpwm_mode_t      mode_reg [NUM_CH];
  logic [CNT_W-1:0] duty_reg [NUM_CH];
  logic [CNT_W-1:0] prd_reg  [NUM_CH];
  logic [CNT_W-1:0] cnt_reg  [NUM_CH];
  logic [CNT_W-1:0] upd_reg  [NUM_CH];
  logic [NUM_CH-1:0] upd_pend_reg, out_reg, ctick;
  fcpwm_dir_t       dir_reg  [NUM_CH];
  logic [31:0]      ch_rd    [NUM_CH];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic             sel, wr_cmr, wr_dty, wr_prd, wr_upd, top;
    logic [CNT_W-1:0] cnt_next;
    fcpwm_dir_t       dir_next;
    assign sel    = ch_ok && ch_idx == 3'(i);
    assign wr_cmr = wr_acc && sel && ch_off == CH_CMR;
    assign wr_dty = wr_acc && sel && ch_off == CH_DUTY_VALUE;
    assign wr_prd = wr_acc && sel && ch_off == CH_PERIOD_VALUE;
    assign wr_upd = wr_acc && sel && ch_off == CH_CUPD;
    // Reserved select codes leave the counter frozen
    assign ctick[i] = chen_reg[i] && mode_reg[i].clk_sel <= SEL_DIVIDED_CLOCK_B
                    && src_tick[mode_reg[i].clk_sel];
    assign top = {1'b0, cnt_reg[i]} + 1'b1 >= {1'b0, prd_reg[i]};

    // Counter stepping for both alignments
    always_comb begin
      cnt_next = cnt_reg[i];
      dir_next = dir_reg[i];
      pend[i]  = 1'b0;
      if (wr_ena && wbits[i]) begin
        cnt_next = '0;
        dir_next = CNT_UP;
      end else if (ctick[i] && !mode_reg[i].centre) begin
        pend[i]  = top;
        cnt_next = top ? '0 : cnt_reg[i] + 1'b1;
      end else if (ctick[i]) begin
        case (dir_reg[i])
          CNT_UP: begin
            if (cnt_reg[i] >= prd_reg[i]) begin
              dir_next = CNT_DOWN;
              if (cnt_reg[i] != '0) cnt_next = cnt_reg[i] - 1'b1;
            end else begin
              cnt_next = cnt_reg[i] + 1'b1;
            end
          end
          CNT_DOWN: begin
            if (cnt_reg[i] <= CNT_W'(1)) begin
              cnt_next = '0;
              dir_next = CNT_UP;
              pend[i]  = 1'b1;
            end else begin
              cnt_next = cnt_reg[i] - 1'b1;
            end
          end
          default: dir_next = CNT_UP;
        endcase
      end
    end

    // Channel registers; upper bus bits beyond the counter are dropped
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        mode_reg[i]     <= '0;
        duty_reg[i]     <= '0;
        prd_reg[i]      <= '0;
        cnt_reg[i]      <= '0;
        upd_reg[i]      <= '0;
        upd_pend_reg[i] <= 1'b0;
        dir_reg[i]      <= CNT_UP;
        out_reg[i]      <= 1'b0;
      end else begin
        cnt_reg[i] <= cnt_next;
        dir_reg[i] <= dir_next;
        // Reserved mode bits are dropped so they always read back as zero
        if (wr_cmr) mode_reg[i] <= fcpwm_mode_t'(pwdata[MODE_W-1:0] & MODE_MASK);
        if (wr_dty) duty_reg[i] <= pwdata[CNT_W-1:0];
        if (wr_prd) prd_reg[i] <= pwdata[CNT_W-1:0];
        // Held value applies only when the running period ends
        if (pend[i] && upd_pend_reg[i]) begin
          if (mode_reg[i].upd_period) prd_reg[i] <= upd_reg[i];
          else duty_reg[i] <= upd_reg[i];
        end
        if (wr_upd) upd_reg[i] <= pwdata[CNT_W-1:0];
        // A fresh update written at the apply edge stays pending
        upd_pend_reg[i] <= wr_upd || (upd_pend_reg[i] && !pend[i]);
        // Start level until the duty match, opposite level after it
        out_reg[i] <= chen_next[i] && ((cnt_next < duty_reg[i])
                    ? mode_reg[i].pol_high : !mode_reg[i].pol_high);
      end
    end

    // Channel read word
    always_comb begin
      ch_rd[i] = RST_ZERO;
      if (sel) begin
        case (ch_off)
          CH_CMR:  ch_rd[i][MODE_W-1:0] = mode_reg[i];
          CH_DUTY_VALUE: ch_rd[i][CNT_W-1:0] = duty_reg[i];
          CH_PERIOD_VALUE: ch_rd[i][CNT_W-1:0] = prd_reg[i];
          CH_CCNT: ch_rd[i][CNT_W-1:0] = cnt_reg[i];
          default: ch_rd[i] = RST_ZERO;
        endcase
      end
    end
  end
  assign pwm_out = out_reg;

  // Read multiplexer; write-only and unmapped words read zero
  always_comb begin
    rd_mux = RST_ZERO;
    case (paddr)
      OFF_MODE: rd_mux = gmode_reg;
      OFF_SR:   rd_mux[NUM_CH-1:0] = chen_reg;
      OFF_IMR:  rd_mux[NUM_CH-1:0] = imr_reg;
      OFF_ISR:  rd_mux[NUM_CH-1:0] = isr_reg | pend;
      default:  rd_mux = RST_ZERO;
    endcase
    for (int j = 0; j < NUM_CH; j++) rd_mux = rd_mux | ch_rd[j];
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_upd_armed(int c);
    upd_pend_reg[c] && !(wr_acc && ch_ok && ch_idx == 3'(c) && ch_off == CH_CUPD);
  endsequence
  sequence s_period_end(int c);
    pend[c] && upd_pend_reg[c];
  endsequence

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chk_ch
    disable_stop_a: assert property ((wr_dis && wbits[i])
      |=> !chen_reg[i] ##1 !pwm_out[i]) else $error("disable did not stop output");
    ier_sets_a: assert property ((wr_ier && wbits[i])
      |=> imr_reg[i]) else $error("interrupt enable did not set mask");
    idr_clears_a: assert property ((wr_idr && wbits[i])
      |=> !imr_reg[i]) else $error("interrupt disable did not clear mask");
    flag_set_a: assert property (pend[i] |=> isr_reg[i])
      else $error("period end not flagged");
    clear_write_a: assert property ((wr_iclr && wbits[i] && !pend[i])
      |=> !isr_reg[i]) else $error("status clear write did not clear");
    read_clear_a: assert property ((rd_isr_done && isr_taken_reg[i] && !pend[i]
      && !$past(pend[i])) |=> !isr_reg[i]) else $error("status read did not clear");
    irq_raise_a: assert property ((pend[i] && imr_reg[i] && !wr_idr)
      |=> irq) else $error("unmasked period end without interrupt");
    prescale_one_a: assert property ((ctick[i] && mode_reg[i].clk_sel == 4'h1
      && !wr_acc) |=> !ctick[i]) else $error("divide by two ticked twice");
    upd_period_a: assert property ((s_period_end(i) ##0 mode_reg[i].upd_period
      && !wr_acc) |=> prd_reg[i] == $past(upd_reg[i])) else $error("period not updated");
    upd_duty_a: assert property ((s_period_end(i) ##0 !mode_reg[i].upd_period
      && !wr_acc) |=> duty_reg[i] == $past(upd_reg[i])) else $error("duty not updated");
    upd_hold_a: assert property ((s_upd_armed(i) ##0 !pend[i] ##0 !wr_acc)
      |=> upd_pend_reg[i] && $stable(duty_reg[i])) else $error("update applied early");
    enable_zero_a: assert property ((wr_ena && wbits[i])
      |=> chen_reg[i] && cnt_reg[i] == '0) else $error("enable did not restart counter");
    left_wrap_a: assert property ((ctick[i] && !mode_reg[i].centre && prd_reg[i] > 1
      && cnt_reg[i] == prd_reg[i] - 1'b1 && !wr_acc) |=> cnt_reg[i] == '0)
      else $error("left aligned counter did not wrap");
    centre_turn_a: assert property ((ctick[i] && mode_reg[i].centre && dir_reg[i] == CNT_UP
      && cnt_reg[i] == prd_reg[i] && prd_reg[i] > 1 && !wr_acc) |=> dir_reg[i] == CNT_DOWN
      && cnt_reg[i] == $past(cnt_reg[i]) - 1'b1) else $error("centre count did not turn");
    // Level checks skip tick edges: there the output already follows the next count
    duty_level_a: assert property ((chen_reg[i] && !wr_acc && cnt_reg[i] >= duty_reg[i]
      && !ctick[i]) |=> pwm_out[i] != mode_reg[i].pol_high)
      else $error("output not at opposite level past duty");
    start_level_a: assert property ((chen_reg[i] && !wr_acc && cnt_reg[i] == '0
      && duty_reg[i] != '0 && !ctick[i]) |=> pwm_out[i] == mode_reg[i].pol_high)
      else $error("period did not start at polarity level");
  end

  status_read_a: assert property ((setup_ph && paddr == OFF_SR)
    |=> prdata[NUM_CH-1:0] == $past(chen_reg)) else $error("status read wrong");
  mask_read_a: assert property ((setup_ph && paddr == OFF_IMR)
    |=> prdata[NUM_CH-1:0] == $past(imr_reg)) else $error("mask read wrong");
  // Divide by two from the undivided clock must skip every other cycle
  div_half_a: assert property ((div_tick[0] && gmode_reg[DIVA_LSB +: 8] == 8'h02
    && gmode_reg[PREA_LSB +: 4] == 4'h0 && !wr_mode) |=> !div_tick[0])
    else $error("divided clock ticked twice in a row");
  duty_width_a: assert property ((setup_ph && ch_ok && ch_off == CH_DUTY_VALUE)
    |=> prdata[31:CNT_W] == '0) else $error("duty upper bits not zero");
endmodule

// ===== verification/fcpwm_load.sv
// External load model: samples the channel pins, counts high levels and rising edges
`timescale 1ns/1ps
module fcpwm_load
  import fcpwm_pkg::*;
(
  input  wire logic       core_clk,   // Master clock
  input  wire logic       rst,        // Reset, high
  input  wire logic [3:0] pwm_out,    // Channel pins
  input  wire logic       clr,        // Clear the counts
  input  wire logic       measure,    // Count while high
  output logic      [7:0] hi_cnt [4], // High samples per pin
  output logic      [7:0] up_cnt [4]  // Rising edges per pin
);
  // ****************************************
  // Level and edge counting
  // ****************************************
  logic [3:0] prev_q; // Pin levels one edge earlier
  // A window that spans whole periods gives exact counts whatever its phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        hi_cnt[c] <= 8'h00;
        up_cnt[c] <= 8'h00;
      end
    end else begin
      prev_q <= pwm_out;
      for (int c = 0; c < 4; c++) begin
        if (clr) begin
          hi_cnt[c] <= 8'h00;
          up_cnt[c] <= 8'h00;
        end else if (measure) begin
          hi_cnt[c] <= hi_cnt[c] + 8'(pwm_out[c]);
          up_cnt[c] <= up_cnt[c] + 8'(pwm_out[c] & ~prev_q[c]);
        end
      end
    end
  end
endmodule

// ===== verification/fcpwm_top_test.sv
// Self-checking bench for the four channel PWM controller
`timescale 1ns/1ps
module fcpwm_top_test
  import fcpwm_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic              core_clk, rst, psel, penable, pwrite, measure, clr, err;
  logic              pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pwm_out;
  logic [7:0]        hi_cnt [4];
  logic [7:0]        up_cnt [4];
  int                num_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  fcpwm_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
  fcpwm_load load (.core_clk(core_clk), .rst(rst), .pwm_out(pwm_out), .clr(clr),
    .measure(measure), .hi_cnt(hi_cnt), .up_cnt(up_cnt));
  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    check("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  function automatic logic [11:0] cha(input int c, input logic [4:0] off);
    return {CH_PAGE, 8'h00} + 12'(c * 32) + {7'h00, off};
  endfunction
  // Counts a 128 cycle window at the load
  task automatic meas(input int c, input logic [7:0] eh, input logic [7:0] eu);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr     <= 1'b0;
    measure <= 1'b1;
    cyc(128);
    measure <= 1'b0;
    @(posedge core_clk);
    check("high samples", {24'h0, eh}, {24'h0, hi_cnt[c]});
    check("rising edges", {24'h0, eu}, {24'h0, up_cnt[c]});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdc("channel_status", OFF_SR, 32'h0);
    rdc("irq_mask", OFF_IMR, 32'h0);
    rdc("irq_status", OFF_ISR, 32'h0);
    rdc("channel_disable", OFF_DIS, 32'h0);
    rdc("unmapped", 12'h100, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    check("irq", 32'h0, {31'h0, irq});
  endtask
  task automatic t_enable();
    apb(1'b1, cha(0, CH_PERIOD_VALUE), 32'h4);
    apb(1'b1, cha(0, CH_DUTY_VALUE), 32'h0);
    apb(1'b1, OFF_ENA, 32'h1);
    rdc("channel_status", OFF_SR, 32'h1);
    check("pwm_out0", 32'h1, {31'h0, pwm_out[0]});
    apb(1'b1, OFF_DIS, 32'h0);
    rdc("channel_status", OFF_SR, 32'h1);
    apb(1'b1, OFF_DIS, 32'h1);
    rdc("channel_status", OFF_SR, 32'h0);
    check("pwm_out0", 32'h0, {31'h0, pwm_out[0]});
    apb(1'b1, OFF_ENA, 32'hf);
    rdc("channel_status", OFF_SR, 32'hf);
    apb(1'b1, OFF_DIS, 32'ha);
    apb(1'b1, OFF_ENA, 32'h0);
    rdc("channel_status", OFF_SR, 32'h5);
    apb(1'b1, OFF_DIS, 32'hf);
  endtask
  task automatic t_mask();
    apb(1'b1, OFF_IER, 32'h3);
    apb(1'b1, OFF_IER, 32'h0);
    rdc("irq_mask", OFF_IMR, 32'h3);
    apb(1'b1, OFF_IDR, 32'h1);
    apb(1'b1, OFF_IDR, 32'h0);
    rdc("irq_mask", OFF_IMR, 32'h2);
    apb(1'b1, OFF_IER, 32'hc);
    rdc("irq_mask", OFF_IMR, 32'he);
    apb(1'b1, OFF_IDR, 32'hf);
    rdc("irq_mask", OFF_IMR, 32'h0);
  endtask
  task automatic t_irq();
    apb(1'b1, OFF_ICLR, 32'h5);
    rdc("irq_status", OFF_ISR, 32'ha);
    apb(1'b1, cha(1, CH_PERIOD_VALUE), 32'h4);
    apb(1'b1, cha(1, CH_DUTY_VALUE), 32'h2);
    apb(1'b1, OFF_IER, 32'h2);
    apb(1'b1, OFF_ENA, 32'h2);
    cyc(20);
    check("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IDR, 32'h2);
    cyc(2);
    check("irq", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IER, 32'h2);
    apb(1'b1, OFF_DIS, 32'h2);
    cyc(4);
    rdc("irq_status", OFF_ISR, 32'h2);
    rdc("irq_status", OFF_ISR, 32'h0);
    cyc(2);
    check("irq", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IDR, 32'hf);
  endtask
  // Channel 2, period 8, duty 3, under clock codes 0, 1, 3, divided A and B, both alignments and both polarities
  task automatic t_wave();
    logic [31:0] md [7] = '{32'h000, 32'h001, 32'h003, 32'h100, 32'h200, 32'h00b, 32'h00c};
    logic [7:0]  eh [7] = '{8'h50, 8'h50, 8'h50, 8'h58, 8'h30, 8'h50, 8'h50};
    logic [7:0]  eu [7] = '{8'h10, 8'h08, 8'h02, 8'h08, 8'h10, 8'h08, 8'h08};
    apb(1'b1, OFF_MODE, 32'h0002_0002);
    apb(1'b1, cha(2, CH_PERIOD_VALUE), 32'h8);
    apb(1'b1, cha(2, CH_DUTY_VALUE), 32'h3);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, OFF_DIS, 32'h4);
      apb(1'b1, cha(2, CH_CMR), md[i]);
      rdc("channel_mode", cha(2, CH_CMR), md[i]);
      apb(1'b1, OFF_ENA, 32'h4);
      cyc(70);
      meas(2, eh[i], eu[i]);
    end
    apb(1'b1, OFF_DIS, 32'h4);
  endtask
  // Reserved clock code freezes the counter, so the update must wait
  task automatic t_update();
    apb(1'b1, cha(3, CH_PERIOD_VALUE), 32'h1234_0008);
    rdc("channel_period", cha(3, CH_PERIOD_VALUE), 32'h8);
    apb(1'b1, cha(3, CH_DUTY_VALUE), 32'habcd_0002);
    rdc("channel_duty", cha(3, CH_DUTY_VALUE), 32'h2);
    apb(1'b1, cha(3, CH_CMR), 32'h00d);
    apb(1'b1, OFF_ENA, 32'h8);
    rdc("channel_counter", cha(3, CH_CCNT), 32'h0);
    apb(1'b1, cha(3, CH_CUPD), 32'hffff_0006);
    cyc(20);
    rdc("channel_duty", cha(3, CH_DUTY_VALUE), 32'h2);
    apb(1'b1, cha(3, CH_CMR), 32'h000);
    cyc(20);
    rdc("channel_duty", cha(3, CH_DUTY_VALUE), 32'h6);
    meas(3, 8'h20, 8'h10);
    apb(1'b1, cha(3, CH_CMR), 32'h400);
    apb(1'b1, cha(3, CH_CUPD), 32'h10);
    cyc(40);
    rdc("channel_period", cha(3, CH_PERIOD_VALUE), 32'h10);
    meas(3, 8'h50, 8'h08);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    measure = 1'b0;
    clr = 1'b0;
    cyc(4);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_mask();
    t_irq();
    t_wave();
    t_update();
    print_verdict();
  end
endmodule
